// ===== design/prc_pkg.sv
// Shared constants for the punch and record controller.
// Assumes a 20 MHz control clock and a sample tick strobe in that domain.
package prc_pkg;

   localparam int TRACKS = 8;
   localparam int AUDIO_W = 16;
   localparam int POS_W = 24;

   // Synchronised key vector positions
   localparam int KEY_PLAY = 0;
   localparam int KEY_REC = 1;
   localparam int KEY_STOP = 2;
   localparam int KEY_REW = 3;
   localparam int KEY_FFWD = 4;
   localparam int KEY_STORE = 5;
   localparam int KEY_LOC2 = 6;
   localparam int KEY_LOC3 = 7;
   localparam int KEY_AINP = 8;
   localparam int KEY_AREC = 9;
   localparam int KEY_REH = 10;
   localparam int KEY_PUP = 11;
   localparam int KEY_PDN = 12;
   localparam int KEY_FOOT = 13;
   localparam int KEY_N = 14;

   // Crossfade lengths in samples and nominal milliseconds at 48 kHz
   localparam logic [11:0] XF_LEN0 = 12'h210;
   localparam logic [11:0] XF_LEN1 = 12'h3F0;
   localparam logic [11:0] XF_LEN2 = 12'h600;
   localparam logic [11:0] XF_LEN3 = 12'h810;
   localparam logic [15:0] XF_MS0 = 16'h000B;
   localparam logic [15:0] XF_MS1 = 16'h0015;
   localparam logic [15:0] XF_MS2 = 16'h0020;
   localparam logic [15:0] XF_MS3 = 16'h002B;
   // Reciprocal of each length, 2^28 / length
   localparam logic [19:0] XF_INV0 = 20'h7C1F0;
   localparam logic [19:0] XF_INV1 = 20'h41041;
   localparam logic [19:0] XF_INV2 = 20'h2AAAA;
   localparam logic [19:0] XF_INV3 = 20'h1FC07;
   localparam int INV_SHIFT = 16;
   localparam int GAIN_BITS = 12;
   localparam logic [13:0] GAIN_ONE = 14'h1000;
   localparam logic [1:0] FADE_SEL_RST = 2'h0;

   // Pitch limits in cents, one step per key press
   localparam logic signed [15:0] P48_MIN = 16'shFED4;
   localparam logic signed [15:0] P48_MAX = 16'sh0064;
   localparam logic signed [15:0] P44_MIN = 16'shFF38;
   localparam logic signed [15:0] P44_MAX = 16'sh00C8;
   localparam logic signed [15:0] PITCH_STEP_DEF = 16'sh000A;
   localparam logic signed [8:0] PCT_MUL = 9'sh0B9;
   localparam int PCT_SHIFT = 5;

   localparam logic [23:0] PT_IN_RST = 24'h000000;
   localparam logic [23:0] PT_OUT_RST = 24'hFFFFFF;

   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int MSG_TIME_MS = 1500;
   localparam int FLASH_HALF_MS = 250;
   localparam int MSG_CYC = MSG_TIME_MS * (CLK_HZ / 1000);
   localparam int FLASH_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

   typedef enum logic [3:0] {
      ST_STOP = 4'b0001,
      ST_PLAY = 4'b0010,
      ST_REC = 4'b0100,
      ST_DROP = 4'b1000
   } prc_state_t;

   typedef enum logic [3:0] {
      DISP_POS = 4'b0001,
      DISP_INVALID = 4'b0010,
      DISP_FADE = 4'b0100,
      DISP_PITCH = 4'b1000
   } prc_disp_t;

endpackage : prc_pkg

// ===== design/prc_xfade.sv
// One track's crossfade between tape audio and incoming audio.
// Assumes sample_tick_in is a one-cycle strobe per audio sample.
`timescale 1ns/10ps
module prc_xfade #(
   parameter int AW = prc_pkg::AUDIO_W
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic sample_tick_in,
   input wire logic target_in,
   input wire logic [11:0] len_in,
   input wire logic [19:0] inv_in,
   input wire logic signed [AW-1:0] tape_in,
   input wire logic signed [AW-1:0] new_in,
   output logic signed [AW-1:0] mix_out
);

   logic [11:0] cnt;
   logic [31:0] prod;
   logic [13:0] gain;
   logic signed [AW+14:0] acc;

   assign prod = {20'h00000, cnt} * {12'h000, inv_in};
   assign gain = (cnt >= len_in) ? prc_pkg::GAIN_ONE :
                 {2'h0, prod[prc_pkg::INV_SHIFT +: 12]};
   assign acc = tape_in * $signed({1'b0, prc_pkg::GAIN_ONE - gain}) +
                new_in * $signed({1'b0, gain});

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= 12'h000;
      end else if (ce_in && sample_tick_in) begin
         if (target_in && cnt < len_in) begin
            cnt <= cnt + 12'h001;
         end else if (!target_in && cnt != 12'h000) begin
            cnt <= cnt - 12'h001;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mix_out <= '0;
      end else if (ce_in && sample_tick_in) begin
         mix_out <= acc[prc_pkg::GAIN_BITS +: AW];
      end
   end

endmodule : prc_xfade

// ===== design/prc_ctrl.sv
// Punch and record control: transport keys, arm buttons, footswitch,
// automatic punch points, rehearse, crossfade and pitch display.
// Assumes key pins are asynchronous; tape position, rate select and
// sample tick come from logic on ref_clk_in.
`timescale 1ns/10ps
module prc_ctrl #(
   parameter int TRACKS = prc_pkg::TRACKS,
   parameter int AW = prc_pkg::AUDIO_W,
   parameter int MSG_CYC = prc_pkg::MSG_CYC,
   parameter int FLASH_CYC = prc_pkg::FLASH_CYC,
   parameter logic signed [15:0] PITCH_STEP = prc_pkg::PITCH_STEP_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic sample_tick_in,
   input wire logic rate_441_in,
   input wire logic [prc_pkg::POS_W-1:0] tape_pos_in,
   input wire logic play_key_in,
   input wire logic rec_key_in,
   input wire logic stop_key_in,
   input wire logic rew_key_in,
   input wire logic ffwd_key_in,
   input wire logic store_key_in,
   input wire logic loc2_key_in,
   input wire logic loc3_key_in,
   input wire logic auto_input_in,
   input wire logic auto_rec_key_in,
   input wire logic rehearse_key_in,
   input wire logic pitch_up_key_in,
   input wire logic pitch_dn_key_in,
   input wire logic foot_in,
   input wire logic [TRACKS-1:0] arm_key_in,
   input wire logic [TRACKS*AW-1:0] tape_audio_in,
   input wire logic [TRACKS*AW-1:0] new_audio_in,
   output logic xport_play_out,
   output logic rec_mode_out,
   output logic [TRACKS-1:0] trk_write_out,
   output logic [TRACKS-1:0] mon_input_out,
   output logic rec_led_out,
   output logic [TRACKS-1:0] arm_led_out,
   output logic rehearse_lbl_out,
   output logic auto_rec_lbl_out,
   output logic pitch_led_out,
   output logic pitch_up_mark_out,
   output logic pitch_dn_mark_out,
   output logic signed [15:0] pitch_cents_out,
   output logic signed [15:0] pitch_pct_out,
   output logic [3:0] disp_mode_out,
   output logic [15:0] disp_value_out,
   output logic [1:0] fade_sel_out,
   output logic [TRACKS*AW-1:0] mix_audio_out
);

   localparam int NK = prc_pkg::KEY_N + TRACKS;
   localparam int PW = prc_pkg::POS_W;

   generate
      if (TRACKS < 1 || AW < 2 || MSG_CYC < 1 || FLASH_CYC < 1) begin : g_chk
         $error("prc_ctrl: unsupported parameter values");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Key synchronisers and press detection

   logic [NK-1:0] key_raw;
   logic [NK-1:0] key_s1;
   logic [NK-1:0] key_s2;
   logic [NK-1:0] key_s3;
   logic [NK-1:0] press;
   logic [NK-1:0] held;

   assign key_raw = {arm_key_in, foot_in, pitch_dn_key_in,
                     pitch_up_key_in, rehearse_key_in, auto_rec_key_in,
                     auto_input_in, loc3_key_in, loc2_key_in,
                     store_key_in, ffwd_key_in, rew_key_in, stop_key_in,
                     rec_key_in, play_key_in};

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         key_s1 <= '0;
         key_s2 <= '0;
         key_s3 <= '0;
      end else if (ce_in) begin
         key_s1 <= key_raw;
         key_s2 <= key_s1;
         key_s3 <= key_s2;
      end
   end

   assign held = key_s2;
   assign press = key_s2 & ~key_s3;

   logic p_play, p_rec, p_stop, p_wind, p_loc2, p_loc3, p_arec, p_reh;
   logic p_pup, p_pdn, p_foot, h_play, h_rec, h_store, auto_inp;
   logic [TRACKS-1:0] p_arm;

   assign p_play = press[prc_pkg::KEY_PLAY];
   assign p_rec = press[prc_pkg::KEY_REC];
   assign p_stop = press[prc_pkg::KEY_STOP];
   assign p_wind = press[prc_pkg::KEY_REW] | press[prc_pkg::KEY_FFWD];
   assign p_loc2 = press[prc_pkg::KEY_LOC2];
   assign p_loc3 = press[prc_pkg::KEY_LOC3];
   assign p_arec = press[prc_pkg::KEY_AREC];
   assign p_reh = press[prc_pkg::KEY_REH];
   assign p_pup = press[prc_pkg::KEY_PUP];
   assign p_pdn = press[prc_pkg::KEY_PDN];
   assign p_foot = press[prc_pkg::KEY_FOOT];
   assign p_arm = press[prc_pkg::KEY_N +: TRACKS];
   assign h_play = held[prc_pkg::KEY_PLAY];
   assign h_rec = held[prc_pkg::KEY_REC];
   assign h_store = held[prc_pkg::KEY_STORE];
   assign auto_inp = held[prc_pkg::KEY_AINP];

   ////////////////////////////////////////////////////////////////////
   // Record state machine

   prc_pkg::prc_state_t state, next_state;
   logic [TRACKS-1:0] armed, next_armed;
   logic [TRACKS-1:0] rec_trk, next_rec_trk;
   logic pend, next_pend;
   logic no_arm, next_no_arm;
   logic auto_en, rehearse;
   logic [PW-1:0] in_pt, out_pt;
   logic in_rec, pos_before, pos_past, chord, start_req;

   assign in_rec = (state == prc_pkg::ST_REC);
   assign pos_before = tape_pos_in < in_pt;
   assign pos_past = tape_pos_in >= out_pt;
   assign chord = ~h_store & ((p_play & h_rec) | (p_rec & h_play));
   assign start_req = chord | (p_foot & ~in_rec);

   always_comb begin
      next_state = state;
      next_armed = armed;
      next_rec_trk = rec_trk;
      next_pend = pend;
      next_no_arm = no_arm;
      case (state)
         prc_pkg::ST_STOP, prc_pkg::ST_PLAY: begin
            next_armed = armed ^ p_arm;
            if (start_req) begin
               if (auto_en && pos_past) begin
                  next_state = prc_pkg::ST_PLAY;
               end else begin
                  next_state = prc_pkg::ST_REC;
                  next_no_arm = (armed == '0);
                  next_pend = auto_en && pos_before;
                  next_rec_trk = next_pend ? '0 : armed;
               end
            end else if (p_play) begin
               next_state = prc_pkg::ST_PLAY;
            end else if (p_stop || p_wind) begin
               next_state = prc_pkg::ST_STOP;
            end
         end
         prc_pkg::ST_REC: begin
            if (p_stop || p_wind) begin
               next_state = prc_pkg::ST_DROP;
               next_rec_trk = '0;
               next_pend = 1'b0;
            end else if (p_foot || p_play) begin
               next_state = prc_pkg::ST_PLAY;
               next_rec_trk = '0;
               next_pend = 1'b0;
            end else if (auto_en && pos_past) begin
               next_state = prc_pkg::ST_PLAY;
               next_rec_trk = '0;
               next_pend = 1'b0;
            end else if (pend) begin
               if (!pos_before) begin
                  next_pend = 1'b0;
                  next_rec_trk = armed;
               end
            end else begin
               next_rec_trk = rec_trk ^ p_arm;
            end
         end
         prc_pkg::ST_DROP: begin
            next_state = prc_pkg::ST_STOP;
         end
         default: begin
            next_state = prc_pkg::ST_STOP;
            next_rec_trk = '0;
            next_pend = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= prc_pkg::ST_STOP;
         armed <= '0;
         rec_trk <= '0;
         pend <= 1'b0;
         no_arm <= 1'b0;
      end else if (ce_in) begin
         state <= next_state;
         armed <= next_armed;
         rec_trk <= next_rec_trk;
         pend <= next_pend;
         no_arm <= next_no_arm;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auto_en <= 1'b0;
         rehearse <= 1'b0;
      end else if (ce_in) begin
         auto_en <= auto_en ^ p_arec;
         rehearse <= rehearse ^ p_reh;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Punch points, crossfade select, pitch

   logic set_in, set_out, bad_pts, fade_step;
   logic [PW-1:0] next_in_pt, next_out_pt;
   logic [1:0] fade_sel;

   assign set_in = h_store & p_loc2;
   assign set_out = h_store & p_loc3;
   assign next_in_pt = set_in ? tape_pos_in : in_pt;
   assign next_out_pt = set_out ? tape_pos_in : out_pt;
   assign bad_pts = (set_in | set_out) & (next_in_pt > next_out_pt);
   assign fade_step = h_store & p_rec;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         in_pt <= prc_pkg::PT_IN_RST;
         out_pt <= prc_pkg::PT_OUT_RST;
         fade_sel <= prc_pkg::FADE_SEL_RST;
      end else if (ce_in) begin
         in_pt <= next_in_pt;
         out_pt <= next_out_pt;
         if (fade_step) begin
            fade_sel <= fade_sel + 2'h1;
         end
      end
   end

   logic signed [15:0] pitch, p_lo, p_hi, next_pitch;
   logic signed [16:0] p_sum;
   logic signed [24:0] pct_prod;
   logic p_adj;

   assign p_adj = p_pup | p_pdn;
   assign p_lo = rate_441_in ? prc_pkg::P44_MIN : prc_pkg::P48_MIN;
   assign p_hi = rate_441_in ? prc_pkg::P44_MAX : prc_pkg::P48_MAX;
   assign p_sum = {pitch[15], pitch} +
                  (p_pup ? {PITCH_STEP[15], PITCH_STEP} :
                   p_pdn ? -{PITCH_STEP[15], PITCH_STEP} : 17'sh00000);
   assign next_pitch = (p_sum < 17'(p_lo)) ? p_lo :
                       (p_sum > 17'(p_hi)) ? p_hi : p_sum[15:0];
   assign pct_prod = pitch * prc_pkg::PCT_MUL;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pitch <= 16'sh0000;
         pitch_pct_out <= 16'sh0000;
      end else if (ce_in) begin
         pitch <= next_pitch;
         pitch_pct_out <= pct_prod[prc_pkg::PCT_SHIFT +: 16];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Time display messages and flash timing

   prc_pkg::prc_disp_t disp;
   logic [31:0] msg_cnt, flash_cnt;
   logic flash_ph;
   logic [15:0] fade_ms;

   assign fade_ms = (fade_sel == 2'h0) ? prc_pkg::XF_MS0 :
                    (fade_sel == 2'h1) ? prc_pkg::XF_MS1 :
                    (fade_sel == 2'h2) ? prc_pkg::XF_MS2 : prc_pkg::XF_MS3;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         disp <= prc_pkg::DISP_POS;
         msg_cnt <= 32'h00000000;
      end else if (ce_in) begin
         if (bad_pts) begin
            disp <= prc_pkg::DISP_INVALID;
            msg_cnt <= MSG_CYC[31:0];
         end else if (fade_step) begin
            disp <= prc_pkg::DISP_FADE;
            msg_cnt <= MSG_CYC[31:0];
         end else if (p_adj) begin
            disp <= prc_pkg::DISP_PITCH;
            msg_cnt <= MSG_CYC[31:0];
         end else if (msg_cnt > 32'h00000001) begin
            msg_cnt <= msg_cnt - 32'h00000001;
         end else begin
            disp <= prc_pkg::DISP_POS;
            msg_cnt <= 32'h00000000;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flash_cnt <= 32'h00000000;
         flash_ph <= 1'b0;
      end else if (ce_in) begin
         if (flash_cnt >= FLASH_CYC[31:0] - 32'h00000001) begin
            flash_cnt <= 32'h00000000;
            flash_ph <= ~flash_ph;
         end else begin
            flash_cnt <= flash_cnt + 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Indicators and transport

   logic rec_flash;

   assign rec_flash = rehearse | pend | (no_arm & (rec_trk == '0));
   assign rec_led_out = in_rec & (rec_flash ? flash_ph : 1'b1);
   assign arm_led_out = rec_trk | (armed & ~rec_trk & {TRACKS{flash_ph}});
   assign xport_play_out = (state != prc_pkg::ST_STOP);
   assign rec_mode_out = in_rec;
   assign trk_write_out = rehearse ? '0 : rec_trk;
   assign mon_input_out = (rehearse && !auto_inp) ? '0 : rec_trk;
   assign rehearse_lbl_out = rehearse;
   assign auto_rec_lbl_out = auto_en;
   assign pitch_led_out = (disp == prc_pkg::DISP_PITCH);
   assign pitch_up_mark_out = (disp == prc_pkg::DISP_POS) && (pitch > 0);
   assign pitch_dn_mark_out = (disp == prc_pkg::DISP_POS) && (pitch < 0);
   assign pitch_cents_out = pitch;
   assign disp_mode_out = disp;
   assign disp_value_out = (disp == prc_pkg::DISP_FADE) ? fade_ms :
                           (disp == prc_pkg::DISP_PITCH) ? pitch :
                           16'h0000;
   assign fade_sel_out = fade_sel;

   ////////////////////////////////////////////////////////////////////
   // Per-track crossfades

   logic [11:0] xf_len;
   logic [19:0] xf_inv;

   assign xf_len = (fade_sel == 2'h0) ? prc_pkg::XF_LEN0 :
                   (fade_sel == 2'h1) ? prc_pkg::XF_LEN1 :
                   (fade_sel == 2'h2) ? prc_pkg::XF_LEN2 : prc_pkg::XF_LEN3;
   assign xf_inv = (fade_sel == 2'h0) ? prc_pkg::XF_INV0 :
                   (fade_sel == 2'h1) ? prc_pkg::XF_INV1 :
                   (fade_sel == 2'h2) ? prc_pkg::XF_INV2 : prc_pkg::XF_INV3;

   genvar t;
   generate
      for (t = 0; t < TRACKS; t++) begin : g_xf
         prc_xfade #(
            .AW(AW)
         ) u_xf (
            .ref_clk_in(ref_clk_in),
            .rst_n_in(rst_n_in),
            .ce_in(ce_in),
            .sample_tick_in(sample_tick_in),
            .target_in(trk_write_out[t]),
            .len_in(xf_len),
            .inv_in(xf_inv),
            .tape_in(tape_audio_in[t*AW +: AW]),
            .new_in(new_audio_in[t*AW +: AW]),
            .mix_out(mix_audio_out[t*AW +: AW])
         );
      end
   endgenerate

endmodule : prc_ctrl

// ===== bench/prc_ctrl_asserts.sv
// Port checker for the punch and record controller.
// Assumes it is bound to prc_ctrl and that keys stay up several cycles.
`timescale 1ns/10ps
module prc_ctrl_asserts #(
   parameter int TRACKS = prc_pkg::TRACKS
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic rate_441_in,
   input wire logic play_key_in,
   input wire logic rec_key_in,
   input wire logic stop_key_in,
   input wire logic store_key_in,
   input wire logic foot_in,
   input wire logic auto_input_in,
   input wire logic xport_play_out,
   input wire logic rec_mode_out,
   input wire logic [TRACKS-1:0] trk_write_out,
   input wire logic [TRACKS-1:0] mon_input_out,
   input wire logic rec_led_out,
   input wire logic rehearse_lbl_out,
   input wire logic auto_rec_lbl_out,
   input wire logic pitch_up_mark_out,
   input wire logic signed [15:0] pitch_cents_out,
   input wire logic [3:0] disp_mode_out,
   input wire logic [1:0] fade_sel_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_chord;
      ce_in && !rec_mode_out && !auto_rec_lbl_out && !store_key_in
         && rec_key_in && $rose(play_key_in);
   endsequence
   sequence s_stop_rec;
      rec_mode_out && $rose(stop_key_in);
   endsequence
   sequence s_drop;
      !rec_mode_out && xport_play_out && trk_write_out == '0;
   endsequence

   chk_chord_records: assert property (
      s_chord |-> ##[3:4] rec_mode_out && xport_play_out)
      else $error("chord did not start recording");
   chk_stop_order: assert property (
      s_stop_rec |-> ##[3:4] s_drop ##1 !xport_play_out)
      else $error("stop did not leave record before halting");
   chk_foot_plays: assert property (
      rec_mode_out && $rose(foot_in) |-> ##[3:4] s_drop)
      else $error("footswitch in record did not return to play");
   chk_leave_plays: assert property (
      $fell(rec_mode_out) |-> xport_play_out)
      else $error("transport halted while leaving record");
   chk_write_in_rec: assert property (
      |trk_write_out |-> rec_mode_out && !rehearse_lbl_out)
      else $error("tape written outside record");
   chk_led_solid: assert property (
      |trk_write_out |-> rec_led_out)
      else $error("record light dark while writing");
   chk_rehearse_mon: assert property (
      (!auto_input_in) [*4] ##0 rehearse_lbl_out |-> mon_input_out == '0)
      else $error("rehearse switched monitor without auto input");
   chk_pitch_range: assert property (
      $stable(rate_441_in) |->
      pitch_cents_out <= (rate_441_in ? 200 : 100) &&
      pitch_cents_out >= (rate_441_in ? -200 : -300))
      else $error("pitch outside its range");
   chk_up_marker: assert property (
      disp_mode_out == 4'h1 |-> pitch_up_mark_out == (pitch_cents_out > 0))
      else $error("up marker wrong");
   chk_fade_step: assert property (
      $changed(fade_sel_out) |-> fade_sel_out == $past(fade_sel_out) + 2'h1)
      else $error("crossfade setting skipped");
endmodule : prc_ctrl_asserts

// ===== bench/prc_xport_model.sv
// Tape transport stand-in: sample strobe and a running tape counter.
// Assumes the bench loads a position only while it wants a jump.
`timescale 1ns/10ps
module prc_xport_model (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic play_in,
   input wire logic load_in,
   input wire logic [23:0] load_pos_in,
   output logic sample_tick_out,
   output logic [23:0] tape_pos_out
);
   // Tape moves one position per sample while playing
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sample_tick_out <= 1'b0;
         tape_pos_out <= 24'h000000;
      end else begin
         sample_tick_out <= !sample_tick_out;
         if (load_in) begin
            tape_pos_out <= load_pos_in;
         end else if (play_in && sample_tick_out) begin
            tape_pos_out <= tape_pos_out + 24'h000001;
         end
      end
   end
endmodule : prc_xport_model

// ===== bench/tb_top.sv
// Bench for the punch and record controller: keys, points, fade, pitch.
// Assumes short message and flash counts given through parameters.
`timescale 1ns/10ps
module tb_top;
   localparam int MSG = 20;
   logic clk = 1'b0, rst_n = 1'b0, rate = 1'b0, ld = 1'b0, v;
   logic [13:0] key = 14'h0000;
   logic [7:0] arm = 8'h00, wr, mon, aled;
   logic [127:0] mix;
   logic [23:0] ld_pos = 24'h000000, pos;
   logic tick, play, rec, led, reh, upm, dnm, pled, alb;
   logic [3:0] dmode;
   logic [15:0] dval;
   logic [1:0] fsel;
   logic signed [15:0] cents, pct;
   logic [15:0] ms [4] = '{prc_pkg::XF_MS0, prc_pkg::XF_MS1,
      prc_pkg::XF_MS2, prc_pkg::XF_MS3};
   int errors = 0, tests_run = 0;

   prc_ctrl #(.MSG_CYC(MSG), .FLASH_CYC(4)) u_dut (
      .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
      .sample_tick_in(tick), .rate_441_in(rate), .tape_pos_in(pos),
      .play_key_in(key[0]), .rec_key_in(key[1]), .stop_key_in(key[2]),
      .rew_key_in(key[3]), .ffwd_key_in(key[4]), .store_key_in(key[5]),
      .loc2_key_in(key[6]), .loc3_key_in(key[7]), .auto_input_in(key[8]),
      .auto_rec_key_in(key[9]), .rehearse_key_in(key[10]),
      .pitch_up_key_in(key[11]), .pitch_dn_key_in(key[12]),
      .foot_in(key[13]), .arm_key_in(arm),
      .tape_audio_in({8{16'h1234}}), .new_audio_in({8{16'hEDCB}}),
      .xport_play_out(play), .rec_mode_out(rec), .trk_write_out(wr),
      .mon_input_out(mon), .rec_led_out(led), .arm_led_out(aled),
      .rehearse_lbl_out(reh), .auto_rec_lbl_out(alb), .pitch_led_out(pled),
      .pitch_up_mark_out(upm), .pitch_dn_mark_out(dnm),
      .pitch_cents_out(cents), .pitch_pct_out(pct), .disp_mode_out(dmode),
      .disp_value_out(dval), .fade_sel_out(fsel), .mix_audio_out(mix));
   prc_xport_model u_xport (.ref_clk_in(clk), .rst_n_in(rst_n),
      .play_in(play), .load_in(ld), .load_pos_in(ld_pos),
      .sample_tick_out(tick), .tape_pos_out(pos));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic check(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic press(input int k);
      key[k] = 1'b1;
      cyc(4);
      key[k] = 1'b0;
      cyc(5);
   endtask : press
   task automatic combo(input int h, input int k);
      key[h] = 1'b1;
      cyc(2);
      press(k);
      key[h] = 1'b0;
      cyc(3);
   endtask : combo
   task automatic tap(input int t);
      arm[t] = 1'b1;
      cyc(4);
      arm[t] = 1'b0;
      cyc(5);
   endtask : tap
   task automatic at(input logic [23:0] p);
      ld_pos = p;
      ld = 1'b1;
      cyc(1);
      ld = 1'b0;
   endtask : at
   task automatic give_verdict;
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   // Watchdog: the sequence needs about 1300 cycles
   initial begin
      #1000000;
      errors++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      cyc(3);
      check("reset", {dmode, fsel, rec, cents}, 23'h080000);
      check("mix", mix[15:0], 16'h1234);
      tap(0);
      combo(1, 0);
      check("write", {wr, led}, 9'h003);
      tap(1);
      check("write", wr, 8'h03);
      check("arm led", aled, 8'h03);
      tap(0);
      check("write", wr, 8'h02);
      press(13);
      check("foot out", {rec, play, wr}, 10'h100);
      press(13);
      check("foot in", {rec, wr}, 9'h101);
      press(2);
      check("stop", {rec, play, wr}, 10'h000);
      tap(0);
      combo(1, 0);
      v = led;
      cyc(4);
      check("flash", {rec, led}, {1'b1, ~v});
      press(2);
      at(24'h000064);
      combo(5, 6);
      at(24'h000032);
      combo(5, 7);
      check("invalid", dmode, 4'h2);
      cyc(MSG);
      at(24'h0000C8);
      combo(5, 7);
      tap(0);
      press(9);
      check("auto lbl", alb, 1'b1);
      at(24'h00000A);
      combo(1, 0);
      check("pending", {rec, play, wr}, 10'h300);
      v = aled[0];
      cyc(4);
      check("arm flash", aled[0], {~v});
      for (int i = 0; i < 400 && wr !== 8'h01; i++) cyc(1);
      check("punch in", pos >= 24'h000064 && pos < 24'h000067, 1'b1);
      check("fade start", mix[15:0], 16'h1234);
      for (int i = 0; i < 400 && rec === 1'b1; i++) cyc(1);
      check("punch out", {play, wr, pos >= 24'h0000C8}, 10'h201);
      check("fading", mix[15:0] != 16'h1234, 1'b1);
      press(2);
      at(24'h00012C);
      combo(1, 0);
      check("past out", {rec, play}, 2'h1);
      press(2);
      at(24'h000096);
      combo(1, 0);
      check("between", wr, 8'h01);
      press(2);
      key[8] = 1'b1;
      press(10);
      at(24'h000096);
      press(13);
      check("rehearse", {reh, wr, mon}, 17'h10001);
      key[8] = 1'b0;
      cyc(4);
      check("no auto", mon, 8'h00);
      press(2);
      press(10);
      press(9);
      for (int i = 1; i < 5; i++) begin
         combo(5, 1);
         check("fade", {fsel, dval}, {i[1:0], ms[i % 4]});
         cyc(MSG);
      end
      repeat (11) press(11);
      check("pitch", cents, 32'h00000064);
      check("pitch led", pled, 1'b1);
      check("percent", pct, 16'h0242);
      cyc(MSG);
      check("up mark", {upm, dmode}, 5'h11);
      rate = 1'b1;
      press(11);
      check("pitch", cents, 32'h0000006E);
      repeat (32) press(12);
      check("pitch", cents, 32'hFFFFFF38);
      cyc(MSG);
      check("dn mark", dnm, 1'b1);
      give_verdict();
   end
endmodule : tb_top

bind prc_ctrl prc_ctrl_asserts #(.TRACKS(TRACKS)) u_chk (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .rate_441_in(rate_441_in), .play_key_in(play_key_in),
   .rec_key_in(rec_key_in), .stop_key_in(stop_key_in),
   .store_key_in(store_key_in), .foot_in(foot_in),
   .auto_input_in(auto_input_in), .xport_play_out(xport_play_out),
   .rec_mode_out(rec_mode_out), .trk_write_out(trk_write_out),
   .mon_input_out(mon_input_out), .rec_led_out(rec_led_out),
   .rehearse_lbl_out(rehearse_lbl_out),
   .auto_rec_lbl_out(auto_rec_lbl_out),
   .pitch_up_mark_out(pitch_up_mark_out),
   .pitch_cents_out(pitch_cents_out), .disp_mode_out(disp_mode_out),
   .fade_sel_out(fade_sel_out));
